// ===== phe_pkg.sv
// Constants and types for the packet header ECC and payload CRC receiver.
// Assumes a byte stream from a lane merger on the protocol byte clock.
package phe_pkg;

	// Syndrome code of each header bit position, bit 0 first.
	localparam logic [7:0] ECC_CODE [0:63] = '{
		8'h07, 8'h0b, 8'h0d, 8'h0e, 8'h13, 8'h15, 8'h16, 8'h19,
		8'h1a, 8'h1c, 8'h23, 8'h25, 8'h26, 8'h29, 8'h2a, 8'h2c,
		8'h31, 8'h32, 8'h34, 8'h38, 8'h1f, 8'h2f, 8'h37, 8'h3b,
		8'h43, 8'h45, 8'h46, 8'h49, 8'h4a, 8'h4c, 8'h51, 8'h52,
		8'h54, 8'h58, 8'h61, 8'h62, 8'h64, 8'h68, 8'h70, 8'h83,
		8'h85, 8'h86, 8'h89, 8'h8a, 8'h3d, 8'h3e, 8'h4f, 8'h57,
		8'h8c, 8'h91, 8'h92, 8'h94, 8'h98, 8'ha1, 8'ha2, 8'ha4,
		8'ha8, 8'hb0, 8'hc1, 8'hc2, 8'hc4, 8'hc8, 8'hd0, 8'he0};
	// Header width protected by the short code.
	localparam int HDR_BITS = 24;
	// CRC preset and reflected polynomial.
	localparam logic [15:0] CRC_SEED = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	// Synchronization data types.
	localparam logic [5:0] DT_FRAME_START = 6'h00;
	localparam logic [5:0] DT_FRAME_END = 6'h01;
	localparam logic [5:0] DT_LINE_START = 6'h02;
	localparam logic [5:0] DT_LINE_END = 6'h03;
	// First generic short type and first long packet type.
	localparam logic [5:0] DT_GEN_SHORT = 6'h08;
	localparam logic [5:0] DT_LONG_MIN = 6'h10;
	// Index of the last header byte, the ECC byte.
	localparam logic [1:0] HDR_LAST_IDX = 2'h3;

	// Outcome of header decoding.
	typedef enum logic [1:0] {
		PHE_ECC_OK = 2'b00,
		PHE_ECC_FIXED = 2'b01,
		PHE_ECC_BAD = 2'b10
	} phe_ecc_t;

	// Receive sequencer states.
	typedef enum logic [2:0] {
		PHE_IDLE = 3'b000,
		PHE_HDR = 3'b001,
		PHE_PAY = 3'b010,
		PHE_FOOT = 3'b011,
		PHE_DONE = 3'b100
	} phe_state_t;

endpackage

// ===== phe_rx.sv
// Receive side of the low level protocol: header ECC check and correction,
// payload CRC check, short packet decoding and frame numbering.
// Assumes rx_sot pulses after byte alignment, before the first header byte,
// and rx_eot pulses when the lane drops to the low power state.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Syndrome is received ECC xor recomputed parity.
// - Short parity uses codes of bits 0-23.
// - Parity table covers all 64 bit positions.
// - Upper two ECC bits are zero.
// - Header bytes: id, length low, length high.
// - Recompute ECC, decode syndrome, correct.
// - Zero syndrome passes header unchanged.
// - Data-bit syndrome flips that bit.
// - One-hot syndrome is a parity bit error.
// - Unknown syndrome flags uncorrectable header.
// - Decode outcome shown to application.
// - CRC-16 reflected polynomial 0x8408.
// - CRC preset to ones every packet.
// - Shift right, xor poly on mismatch.
// - Empty payload checksum is all ones.
// - Checksum in footer, low byte first.
// - Packets separated by end, idle, start.
// - Sync codes: frame/line start and end.
// - Zero frame number means numbering off.
module phe_rx (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Aligned byte stream from the lane.
	input wire logic rx_sot,
	input wire logic rx_eot,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	// Corrected header and decode outcome.
	output logic hdr_valid,
	output logic [1:0] hdr_vc,
	output logic [5:0] hdr_dt,
	output logic [15:0] hdr_wc,
	output logic [1:0] ecc_status,
	// Short packets.
	output logic short_valid,
	output logic frame_start_packet,
	output logic frame_end_packet,
	output logic line_start_packet,
	output logic line_end_packet,
	output logic [15:0] frame_number,
	output logic frame_num_on,
	output logic frame_num_mismatch,
	// Payload and checksum.
	output logic pay_valid,
	output logic [7:0] pay_data,
	output logic crc_done,
	output logic crc_error,
	output logic [15:0] crc_rx
);

	// Sequencer state.
	phe_pkg::phe_state_t state;
	// Header bytes held until the ECC byte arrives.
	logic [1:0] hdr_cnt;
	logic [7:0] hdr_b0;
	logic [7:0] hdr_b1;
	logic [7:0] hdr_b2;
	// Payload bytes still expected.
	logic [15:0] wc_left;
	// Running CRC and low footer byte.
	logic [15:0] crc;
	logic [7:0] foot_lo;
	logic foot_cnt;
	// Decode results of the header being completed.
	logic [23:0] raw;
	logic [7:0] calc;
	logic [7:0] syn;
	logic [23:0] fixed;
	phe_pkg::phe_ecc_t stat_c;
	logic hdr_last;
	logic is_short;

	// Parity over a 64-bit word; a 24-bit header is zero extended, so the
	// two top parity bits come out zero by construction.
	function automatic logic [7:0] ecc_parity(input logic [63:0] d);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 64; i++) begin
			if (d[i]) begin
				p = p ^ phe_pkg::ECC_CODE[i];
			end
		end
		return p;
	endfunction

	// One payload byte through the serial CRC, bit 0 first.
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ b[i]) begin
				r = (r >> 1) ^ phe_pkg::CRC_POLY;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	// The ECC byte is the fourth header byte.
	assign hdr_last = (state == phe_pkg::PHE_HDR) && rx_byte_valid && (hdr_cnt == phe_pkg::HDR_LAST_IDX);

	// Combinational header decode, done in the cycle the ECC byte arrives
	// so no field is used before correction.
	always_comb begin
		raw = {rx_byte_valid ? hdr_b2 : hdr_b2, hdr_b1, hdr_b0};
		calc = ecc_parity({40'h0, raw});
		syn = rx_byte ^ calc;
		fixed = raw;
		stat_c = phe_pkg::PHE_ECC_OK;
		if (syn != 8'h00) begin
			stat_c = phe_pkg::PHE_ECC_BAD;
			for (int i = 0; i < phe_pkg::HDR_BITS; i++) begin
				if (syn == phe_pkg::ECC_CODE[i]) begin
					fixed[i] = ~raw[i];
					stat_c = phe_pkg::PHE_ECC_FIXED;
				end
			end
			if ($onehot(syn)) begin
				stat_c = phe_pkg::PHE_ECC_FIXED;
			end
		end
		is_short = fixed[5:0] < phe_pkg::DT_LONG_MIN;
	end

	// Sequencer; a start of transmission always realigns, whatever the state,
	// so odd-length gaps between packets are harmless.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= phe_pkg::PHE_IDLE;
			hdr_cnt <= 2'h0;
			wc_left <= 16'h0000;
			foot_cnt <= 1'b0;
		end else if (rx_sot) begin
			state <= phe_pkg::PHE_HDR;
			hdr_cnt <= 2'h0;
			foot_cnt <= 1'b0;
		end else if (rx_eot) begin
			// A packet cut short by the idle state is simply dropped.
			state <= phe_pkg::PHE_IDLE;
		end else if (rx_byte_valid) begin
			case (state)
				phe_pkg::PHE_HDR: begin
					hdr_cnt <= hdr_cnt + 2'h1;
					if (hdr_last) begin
						wc_left <= fixed[23:8];
						if (stat_c == phe_pkg::PHE_ECC_BAD || is_short) begin
							state <= phe_pkg::PHE_DONE;
						end else if (fixed[23:8] == 16'h0000) begin
							state <= phe_pkg::PHE_FOOT;
						end else begin
							state <= phe_pkg::PHE_PAY;
						end
					end
				end
				phe_pkg::PHE_PAY: begin
					wc_left <= wc_left - 16'h0001;
					if (wc_left == 16'h0001) begin
						state <= phe_pkg::PHE_FOOT;
					end
				end
				phe_pkg::PHE_FOOT: begin
					foot_cnt <= 1'b1;
					if (foot_cnt) begin
						state <= phe_pkg::PHE_DONE;
					end
				end
				default: begin
					state <= state;
				end
			endcase
		end
	end

	// Header byte capture.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hdr_b0 <= 8'h00;
			hdr_b1 <= 8'h00;
			hdr_b2 <= 8'h00;
		end else if (state == phe_pkg::PHE_HDR && rx_byte_valid && !rx_sot && !rx_eot) begin
			if (hdr_cnt == 2'h0) begin
				hdr_b0 <= rx_byte;
			end else if (hdr_cnt == 2'h1) begin
				hdr_b1 <= rx_byte;
			end else if (hdr_cnt == 2'h2) begin
				hdr_b2 <= rx_byte;
			end
		end
	end

	// Header and short packet outputs; pulses last one cycle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hdr_valid <= 1'b0;
			{hdr_wc, hdr_vc, hdr_dt} <= 24'h000000;
			ecc_status <= phe_pkg::PHE_ECC_OK;
			short_valid <= 1'b0;
			frame_start_packet <= 1'b0;
			frame_end_packet <= 1'b0;
			line_start_packet <= 1'b0;
			line_end_packet <= 1'b0;
			frame_number <= 16'h0000;
			frame_num_on <= 1'b0;
			frame_num_mismatch <= 1'b0;
		end else begin
			hdr_valid <= 1'b0;
			short_valid <= 1'b0;
			frame_start_packet <= 1'b0;
			frame_end_packet <= 1'b0;
			line_start_packet <= 1'b0;
			line_end_packet <= 1'b0;
			frame_num_mismatch <= 1'b0;
			if (hdr_last && !rx_sot && !rx_eot) begin
				hdr_valid <= 1'b1;
				{hdr_wc, hdr_vc, hdr_dt} <= fixed;
				ecc_status <= stat_c;
				// An uncorrectable header is reported but never acted upon.
				if (stat_c != phe_pkg::PHE_ECC_BAD && is_short) begin
					short_valid <= 1'b1;
					case (fixed[5:0])
						phe_pkg::DT_FRAME_START: begin
							frame_start_packet <= 1'b1;
							frame_number <= fixed[23:8];
							frame_num_on <= fixed[23:8] != 16'h0000;
						end
						phe_pkg::DT_FRAME_END: begin
							frame_end_packet <= 1'b1;
							frame_num_mismatch <= fixed[23:8] != frame_number;
						end
						phe_pkg::DT_LINE_START: begin
							line_start_packet <= 1'b1;
						end
						phe_pkg::DT_LINE_END: begin
							line_end_packet <= 1'b1;
						end
						default: begin
							// Reserved sync codes and generic types only strobe short_valid.
							line_end_packet <= 1'b0;
						end
					endcase
				end
			end
		end
	end

	// Payload forwarding and checksum; the preset happens at every start.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			crc <= phe_pkg::CRC_SEED;
			foot_lo <= 8'h00;
			pay_valid <= 1'b0;
			pay_data <= 8'h00;
			crc_done <= 1'b0;
			crc_error <= 1'b0;
			crc_rx <= 16'h0000;
		end else begin
			pay_valid <= 1'b0;
			crc_done <= 1'b0;
			if (rx_sot) begin
				crc <= phe_pkg::CRC_SEED;
			end else if (rx_byte_valid && !rx_eot && state == phe_pkg::PHE_PAY) begin
				pay_valid <= 1'b1;
				pay_data <= rx_byte;
				crc <= crc_byte(crc, rx_byte);
			end else if (rx_byte_valid && !rx_eot && state == phe_pkg::PHE_FOOT) begin
				if (!foot_cnt) begin
					foot_lo <= rx_byte;
				end else begin
					crc_done <= 1'b1;
					crc_rx <= {rx_byte, foot_lo};
					crc_error <= {rx_byte, foot_lo} != crc;
				end
			end
		end
	end

	// Checks.
	hdr_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
		hdr_last && !rx_sot && !rx_eot |=> hdr_valid && ecc_status == $past(stat_c))
		else $error("header not reported after ECC byte");
	ecc_clean_a: assert property (@(posedge clk) disable iff (sys_rst)
		hdr_last && !rx_sot && !rx_eot && syn == 8'h00 |=> {hdr_wc, hdr_vc, hdr_dt} == $past(raw) && ecc_status == 2'b00)
		else $error("clean header altered");
	ecc_flip_a: assert property (@(posedge clk) disable iff (sys_rst)
		hdr_last && !rx_sot && !rx_eot && syn == 8'h0b |=> {hdr_wc, hdr_vc, hdr_dt} == ($past(raw) ^ 24'h000002))
		else $error("single data bit not corrected");
	ecc_parity_a: assert property (@(posedge clk) disable iff (sys_rst)
		hdr_last && !rx_sot && !rx_eot && $onehot(syn) |=> {hdr_wc, hdr_vc, hdr_dt} == $past(raw) && ecc_status == 2'b01)
		else $error("parity error changed data");
	ecc_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
		hdr_last && !rx_sot && !rx_eot && stat_c == phe_pkg::PHE_ECC_BAD |=> ecc_status == 2'b10 && !short_valid
		&& state == phe_pkg::PHE_DONE)
		else $error("uncorrectable header acted upon");
	crc_preset_a: assert property (@(posedge clk) disable iff (sys_rst)
		rx_sot |=> crc == 16'hffff)
		else $error("CRC not preset at packet start");
	crc_empty_a: assert property (@(posedge clk) disable iff (sys_rst)
		hdr_last && !rx_sot && !rx_eot && stat_c != phe_pkg::PHE_ECC_BAD && !is_short && fixed[23:8] == 16'h0000
		|=> state == phe_pkg::PHE_FOOT && crc == 16'hffff)
		else $error("empty payload CRC not all ones");
	crc_check_a: assert property (@(posedge clk) disable iff (sys_rst)
		crc_done |-> crc_error == (crc_rx != crc) && $past(state) == phe_pkg::PHE_FOOT)
		else $error("checksum flag disagrees with compare");
	frame_num_a: assert property (@(posedge clk) disable iff (sys_rst)
		frame_start_packet |-> frame_num_on == (frame_number != 16'h0000) && short_valid && hdr_dt == 6'h00)
		else $error("frame numbering flag wrong");
	short_fwd_a: assert property (@(posedge clk) disable iff (sys_rst)
		short_valid |-> hdr_dt < 6'h10 && hdr_valid && ecc_status != 2'b10)
		else $error("short packet forwarded wrongly");

endmodule // phe_rx

`default_nettype wire

// ===== phe_rx_note_end.sv
`timescale 1ns/100ps

// ===== phe_tx_model.sv
// Transmitter model that feeds the header ECC and payload CRC receiver.
// Assumes the bench fills pay and calls send from one process at a time.
`timescale 1ns/100ps
`default_nettype none
module phe_tx_model (
	// Clock.
	input wire logic clk,
	// Byte stream towards the receiver.
	output logic rx_sot,
	output logic rx_eot,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte
);
	// Payload bytes of the next long packet.
	logic [7:0] pay [0:31];

	// The lane starts idle.
	initial begin
		rx_sot = 1'b0;
		rx_eot = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
	end

	// One byte per cycle, launched just after an edge.
	task automatic put(input logic [7:0] b);
		@(posedge clk);
		rx_sot <= 1'b0;
		rx_byte_valid <= 1'b1;
		rx_byte <= b;
	endtask

	// Sends one packet; flip spoils header bits, bad spoils the checksum, cut stops early.
	task automatic send(input logic [7:0] id, input logic [15:0] wc, input logic [31:0] flip,
		input logic bad, input int cut);
		logic [31:0] w;
		logic [15:0] c;
		logic [7:0] q [$];
		w = {8'h00, wc, id};
		for (int i = 0; i < 24; i++) if (w[i]) w[29:24] = w[29:24] ^ phe_pkg::ECC_CODE[i][5:0];
		w = w ^ flip;
		c = 16'hffff;
		for (int k = 0; k < wc; k++)
			for (int j = 0; j < 8; j++)
				c = (c[0] ^ pay[k][j]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		c = c ^ {15'h0000, bad};
		q = {w[7:0], w[15:8], w[23:16], w[31:24]};
		// Short types never carry a payload.
		if (id[5:0] >= 6'h10) begin
			for (int k = 0; k < wc; k++) q.push_back(pay[k]);
			q.push_back(c[7:0]);
			q.push_back(c[15:8]);
		end
		@(posedge clk);
		rx_sot <= 1'b1;
		foreach (q[i]) if (cut == 0 || i < cut) put(q[i]);
		// The released line shows the inverse so stale bytes are never trusted.
		@(posedge clk);
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		rx_eot <= 1'b1;
		@(posedge clk);
		rx_eot <= 1'b0;
	endtask
endmodule // phe_tx_model
`default_nettype wire

// ===== phe_rx_tb.sv
// Self-checking bench for the header ECC and payload CRC receiver.
// Assumes phe_tx_model drives the byte stream.
`timescale 1ns/100ps
`default_nettype none
module phe_rx_tb;
	logic clk, sys_rst, rx_sot, rx_eot, rx_byte_valid, hdr_valid, short_valid, pay_valid, crc_done;
	logic frame_start_packet, frame_end_packet, line_start_packet, line_end_packet;
	logic frame_num_on, frame_num_mismatch, crc_error;
	logic [7:0] rx_byte, pay_data;
	logic [1:0] hdr_vc, ecc_status;
	logic [5:0] hdr_dt;
	logic [15:0] hdr_wc, frame_number, crc_rx;
	// Pulse counts since the last packet started, and sync pulses seen.
	logic [15:0] sc, pc, cc, mm;
	// Payload bytes that differ from what the model sent, and header pulses seen.
	logic [15:0] pe, hv;
	logic [3:0] sy;
	int num_errors, comparisons;

	phe_rx phe_rx_inst (.clk(clk), .sys_rst(sys_rst), .rx_sot(rx_sot), .rx_eot(rx_eot),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .hdr_valid(hdr_valid), .hdr_vc(hdr_vc),
		.hdr_dt(hdr_dt), .hdr_wc(hdr_wc), .ecc_status(ecc_status), .short_valid(short_valid),
		.frame_start_packet(frame_start_packet), .frame_end_packet(frame_end_packet),
		.line_start_packet(line_start_packet), .line_end_packet(line_end_packet),
		.frame_number(frame_number), .frame_num_on(frame_num_on), .frame_num_mismatch(frame_num_mismatch),
		.pay_valid(pay_valid), .pay_data(pay_data), .crc_done(crc_done), .crc_error(crc_error), .crc_rx(crc_rx));
	phe_tx_model phe_tx_model_inst (.clk(clk), .rx_sot(rx_sot), .rx_eot(rx_eot),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));

	// 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Pulses are counted because they stand for one cycle only.
	always @(posedge clk) begin
		if (short_valid === 1'b1) sc = sc + 16'h0001;
		if (pay_valid === 1'b1 && pay_data !== phe_tx_model_inst.pay[pc[4:0]]) pe = pe + 16'h0001;
		if (pay_valid === 1'b1) pc = pc + 16'h0001;
		if (hdr_valid === 1'b1) hv = hv + 16'h0001;
		if (crc_done === 1'b1) cc = cc + 16'h0001;
		if (frame_num_mismatch === 1'b1) mm = mm + 16'h0001;
		sy = sy | {line_end_packet, line_start_packet, frame_end_packet, frame_start_packet};
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Clears the counts, sends one packet and lets the last pulses land.
	task automatic pkt(input logic [7:0] id, input logic [15:0] wc, input logic [31:0] flip,
		input logic bad, input int cut);
		{sc, pc, cc, mm, sy, pe, hv} = '0;
		phe_tx_model_inst.send(id, wc, flip, bad, cut);
		repeat (2) @(posedge clk);
	endtask

	// Known payload vectors, first byte in the top bits.
	task automatic t_vec(input logic [191:0] v, input logic [15:0] sum);
		for (int k = 0; k < 24; k++) phe_tx_model_inst.pay[k] = v[191 - 8 * k -: 8];
		pkt(8'h52, 16'h0018, 32'h0, 1'b0, 0);
		chk("status", {14'h0, ecc_status}, 16'h0000);
		chk("vc dt", {8'h0, hdr_vc, hdr_dt}, 16'h0052);
		chk("wc", hdr_wc, 16'h0018);
		chk("pay", pc, 16'h0018);
		chk("paydata", pe, 16'h0000);
		chk("hdrv", hv, 16'h0001);
		chk("crc", crc_rx, sum);
		chk("crcerr", {15'h0, crc_error}, 16'h0000);
	endtask

	// Every single header bit error is repaired, data and parity alike.
	task automatic t_flip;
		for (int i = 0; i < 32; i++) begin
			pkt(8'h09, 16'h1234, 32'h1 << i, 1'b0, 0);
			chk("fix", {14'h0, ecc_status}, 16'h0001);
			chk("fixdt", {8'h0, hdr_vc, hdr_dt}, 16'h0009);
			chk("fixhdr", hv, 16'h0001);
			chk("fixwc", hdr_wc, 16'h1234);
			chk("short", sc, 16'h0001);
		end
	endtask

	// A double error is flagged and its payload is dropped.
	task automatic t_double;
		pkt(8'h2a, 16'h0004, 32'h3, 1'b0, 0);
		chk("bad", {14'h0, ecc_status}, 16'h0002);
		chk("badpay", pc + cc, 16'h0000);
	endtask

	// Empty payload and spoiled checksum.
	task automatic t_crc;
		pkt(8'h12, 16'h0000, 32'h0, 1'b0, 0);
		chk("empty", crc_rx, 16'hffff);
		chk("emptyerr", {15'h0, crc_error}, 16'h0000);
		pkt(8'h2b, 16'h0005, 32'h0, 1'b1, 0);
		chk("crcbad", {15'h0, crc_error}, 16'h0001);
		chk("crcdone", cc, 16'h0001);
	endtask

	// Each sync and reserved code once.
	task automatic t_sync;
		for (int d = 0; d < 8; d++) begin
			pkt(8'(d), 16'h00a5, 32'h0, 1'b0, 0);
			chk("sync", {12'h0, sy}, (d < 4) ? 16'(1 << d) : 16'h0000);
			chk("syncdata", hdr_wc, 16'h00a5);
		end
	endtask

	// Frame numbers: matching, differing and switched off.
	task automatic t_frame;
		pkt(8'h00, 16'h0005, 32'h0, 1'b0, 0);
		chk("fnum", frame_number, 16'h0005);
		chk("fon", {15'h0, frame_num_on}, 16'h0001);
		chk("fstart", {12'h0, sy}, 16'h0001);
		pkt(8'h01, 16'h0005, 32'h0, 1'b0, 0);
		chk("fsame", mm, 16'h0000);
		chk("fend", {12'h0, sy}, 16'h0002);
		pkt(8'h01, 16'h0006, 32'h0, 1'b0, 0);
		chk("fdiff", mm, 16'h0001);
		pkt(8'h00, 16'h0000, 32'h0, 1'b0, 0);
		chk("foff", {15'h0, frame_num_on}, 16'h0000);
	endtask

	// A packet cut short by end of transmission leaves the next one intact.
	task automatic t_cut;
		pkt(8'h2a, 16'h0008, 32'h0, 1'b0, 6);
		chk("cutdone", cc, 16'h0000);
		pkt(8'h2a, 16'h0008, 32'h0, 1'b0, 0);
		chk("after", pc, 16'h0008);
		chk("afterdata", pe, 16'h0000);
		chk("aftererr", {15'h0, crc_error}, 16'h0000);
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence.
	initial begin
		sys_rst = 1'b1;
		num_errors = 0;
		comparisons = 0;
		{sc, pc, cc, mm, sy, pe, hv} = '0;
		for (int k = 0; k < 32; k++) phe_tx_model_inst.pay[k] = 8'(k * 29 + 3);
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk("rst", {14'h0, ecc_status}, 16'h0000);
		t_vec(192'hff000002b9dcf372bbd4b85ac875c27c81f805dfff000001, 16'h00f0);
		t_vec(192'hff0000001ef01ec74f8278c582e08c70d23c78e9ff000001, 16'he569);
		t_flip;
		t_double;
		t_crc;
		t_sync;
		t_frame;
		t_cut;
		end_sim;
	end

	// Hang guard, well beyond the roughly 550 cycles the run needs.
	initial begin
		#100000;
		num_errors++;
		end_sim;
	end
endmodule // phe_rx_tb
`default_nettype wire
